// ### rtl/lcr_defines.svh
// constants of the lane configuration register bank
// What this block does
// - lane d bits 15:12 read zero, ignore writes
// - clock compensation bit ORed with global bit 11
// - select chooses multifunction pin source, four modes
// - pin select is lane OR global bits 10:9
// - loss detection needs lane and global bit 8
// - config bit 7 writable only while strap low
// - config bit 6 writable only while strap low
// - emphasis bits 5:4 ORed with global bits
// - lane d loopback ORed with loopback-all
// - lane d pattern test lockable by test strap
// - lane d alignment needs bit, pin, global
// - lane d power down ORed with power-down-all
// - lane c loopback ORed with loopback-all
// - lane c pattern test lockable by test strap
// - lane c alignment needs bit, pin, global
// - lane c power down ORed with power-down-all
`ifndef LCR_DEFINES_SVH
`define LCR_DEFINES_SVH
// ----------------------------------------------
// bus geometry and register offsets
// ----------------------------------------------
`define LCR_ADDR_W     5
`define LCR_DATA_W     16
`define LCR_OFS_LANE_C 5'h13
`define LCR_OFS_LANE_D 5'h14
// ----------------------------------------------
// field positions
// ----------------------------------------------
`define LCR_B_CTC      11
`define LCR_B_MF_HI    10
`define LCR_B_MF_LO    9
`define LCR_B_LOS      8
`define LCR_B_CFG1     7
`define LCR_B_CFG0     6
`define LCR_B_EMPH_HI  5
`define LCR_B_EMPH_LO  4
`define LCR_B_LOOP     3
`define LCR_B_PATTERN  2
`define LCR_B_ALIGN    1
`define LCR_B_PDOWN    0
// ----------------------------------------------
// reset value, writable mask, pin select codes
// ----------------------------------------------
`define LCR_RST_VAL    16'h0102
`define LCR_WR_MASK    16'h0fff
`define LCR_MF_IOSTD   2'h0
`define LCR_MF_COMMA   2'h1
`define LCR_MF_LOSS    2'h2
`define LCR_MF_PASS    2'h3
`define LCR_NUM_PINS   5
`endif

// ### rtl/lcr_pkg.sv
// types shared by the lane configuration register bank
package lcr_pkg;
    // effective per-lane controls after global merging
    typedef struct packed {
        logic       ctc;        // clock tolerance compensation
        logic [1:0] mf_sel;     // multifunction pin select
        logic       los_en;     // loss-of-signal detection
        logic       cfg1;       // configuration bit 7
        logic       cfg0;       // configuration bit 6
        logic       emph_high;  // emphasis_sel_high
        logic       emph_low;   // emphasis_sel_low
        logic       loopback;   // serial loopback
        logic       pattern_en; // pseudo-random test
        logic       align_en;   // comma detect and align
        logic       power_down; // lane power down
    } lcr_eff_t;
    // synchronised strap and pin levels
    typedef struct packed {
        logic io_std_hstl;          // 1 hstl, 0 sstl_2
        logic alignment_enable_pin; // alignment enable
        logic pattern_test_strap;   // locks pattern bit
        logic config_strap_one;     // locks bit 7
        logic config_strap_zero;    // locks bit 6
    } lcr_straps_t;
endpackage

// ### rtl/lcr_sync.sv
// three-stage synchroniser with agreement filter for strap pins
`timescale 1ns/1ps
`include "lcr_defines.svh"
module lcr_sync
    import lcr_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    input  wire logic [`LCR_NUM_PINS-1:0] pin_in,
    output logic      [`LCR_NUM_PINS-1:0] pin_out
);
    // ----------------------------------------------
    // one filtered chain per pin
    // ----------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `LCR_NUM_PINS; gi++) begin : g_pin
            logic s1_reg, s2_reg, s3_reg;    // flop chain
            logic out_reg, out_next;         // accepted level
            // a change counts once stages two and three agree
            always_comb begin
                out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
            end
            // registers only
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    s1_reg  <= 1'b0;
                    s2_reg  <= 1'b0;
                    s3_reg  <= 1'b0;
                    out_reg <= 1'b0;
                end else begin
                    s1_reg  <= pin_in[gi];
                    s2_reg  <= s1_reg;
                    s3_reg  <= s2_reg;
                    out_reg <= out_next;
                end
            end
            assign pin_out[gi] = out_reg;
        end
    endgenerate
endmodule

// ### rtl/lcr_lane.sv
// one lane control register with its merged effective controls
`timescale 1ns/1ps
`include "lcr_defines.svh"
module lcr_lane
    import lcr_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    input  wire logic                   wr_hit,
    input  wire logic [`LCR_DATA_W-1:0] wdata,
    input  wire logic [`LCR_DATA_W-1:0] global_cfg,
    input  wire logic                   loopback_all,
    input  wire logic                   power_down_all,
    input  wire lcr_straps_t            straps,
    output logic      [`LCR_DATA_W-1:0] ctrl_val,
    output lcr_eff_t                    eff
);
    logic [`LCR_DATA_W-1:0] ctrl_reg, ctrl_next; // software view
    logic [`LCR_DATA_W-1:0] wmask;               // bits open to write
    lcr_eff_t               eff_reg, eff_next;   // merged controls
    // ----------------------------------------------
    // write path
    // ----------------------------------------------
    always_comb begin
        wmask = `LCR_WR_MASK; // reserved bits closed
        if (straps.config_strap_one) begin
            wmask[`LCR_B_CFG1] = 1'b0;
        end
        if (straps.config_strap_zero) begin
            wmask[`LCR_B_CFG0] = 1'b0;
        end
        if (straps.pattern_test_strap) begin
            wmask[`LCR_B_PATTERN] = 1'b0;
        end
        ctrl_next = ctrl_reg;
        if (wr_hit) begin
            ctrl_next = (ctrl_reg & ~wmask) | (wdata & wmask);
        end
    end
    // ----------------------------------------------
    // merge with global controls and pins
    // ----------------------------------------------
    always_comb begin
        eff_next.ctc        = ctrl_reg[`LCR_B_CTC] | global_cfg[`LCR_B_CTC];
        eff_next.mf_sel     = ctrl_reg[`LCR_B_MF_HI:`LCR_B_MF_LO]
                            | global_cfg[`LCR_B_MF_HI:`LCR_B_MF_LO];
        eff_next.los_en     = ctrl_reg[`LCR_B_LOS] & global_cfg[`LCR_B_LOS];
        eff_next.cfg1       = ctrl_reg[`LCR_B_CFG1] | global_cfg[`LCR_B_CFG1];
        eff_next.cfg0       = ctrl_reg[`LCR_B_CFG0] | global_cfg[`LCR_B_CFG0];
        eff_next.emph_high  = ctrl_reg[`LCR_B_EMPH_HI] | global_cfg[`LCR_B_EMPH_HI];
        eff_next.emph_low   = ctrl_reg[`LCR_B_EMPH_LO] | global_cfg[`LCR_B_EMPH_LO];
        eff_next.loopback   = ctrl_reg[`LCR_B_LOOP] | loopback_all;
        eff_next.pattern_en = ctrl_reg[`LCR_B_PATTERN]
                            | global_cfg[`LCR_B_PATTERN];
        eff_next.align_en   = ctrl_reg[`LCR_B_ALIGN] & straps.alignment_enable_pin
                            & global_cfg[`LCR_B_ALIGN];
        eff_next.power_down = ctrl_reg[`LCR_B_PDOWN] | power_down_all;
    end
    // registers only
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= `LCR_RST_VAL;
            eff_reg  <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
            eff_reg  <= eff_next;
        end
    end
    assign ctrl_val = ctrl_reg;
    assign eff      = eff_reg;
endmodule

// ### rtl/lcr_top.sv
// lane c and lane d control registers with merged outputs
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "lcr_defines.svh"
module lcr_top
    import lcr_pkg::*;
(
    input  wire logic                   CLK,
    input  wire logic                   ARST_N,
    input  wire logic [`LCR_ADDR_W-1:0] ADDR,
    input  wire logic [`LCR_DATA_W-1:0] WDATA,
    input  wire logic                   WR,
    input  wire logic                   RD,
    output logic      [`LCR_DATA_W-1:0] RDATA,
    input  wire logic [`LCR_DATA_W-1:0] GLOBAL_CFG,
    input  wire logic                   LOOPBACK_ALL,
    input  wire logic                   POWER_DOWN_ALL,
    input  wire logic                   CONFIG_STRAP_ZERO,
    input  wire logic                   CONFIG_STRAP_ONE,
    input  wire logic                   PATTERN_TEST_STRAP,
    input  wire logic                   ALIGNMENT_ENABLE_PIN,
    input  wire logic                   IO_STD_HSTL,
    input  wire logic                   LANE_D_COMMA_DETECTED,
    input  wire logic                   LANE_D_SIGNAL_LOSS,
    input  wire logic                   LANE_D_PATTERN_TEST_PASS,
    output logic                        LANE_D_MULTIFUNCTION_PIN,
    output lcr_eff_t                    LANE_C_CTRL,
    output lcr_eff_t                    LANE_D_CTRL
);
    // ----------------------------------------------
    // declarations
    // ----------------------------------------------
    lcr_straps_t            straps_raw;   // pins as they arrive
    lcr_straps_t            straps;       // filtered pins
    logic                   hit_c;        // address decodes to lane c
    logic                   hit_d;        // address decodes to lane d
    logic [`LCR_DATA_W-1:0] c_val;        // lane c register
    logic [`LCR_DATA_W-1:0] d_val;        // lane d register
    logic [`LCR_DATA_W-1:0] rdata_reg;    // read answer
    logic [`LCR_DATA_W-1:0] rdata_next;   // next read answer
    logic                   mf_reg;       // multifunction pin
    logic                   mf_next;      // next pin level

    // ----------------------------------------------
    // strap pin synchronisation
    // ----------------------------------------------
    // straps come from outside the clock domain
    always_comb begin
        straps_raw.io_std_hstl          = IO_STD_HSTL;
        straps_raw.alignment_enable_pin = ALIGNMENT_ENABLE_PIN;
        straps_raw.pattern_test_strap   = PATTERN_TEST_STRAP;
        straps_raw.config_strap_one     = CONFIG_STRAP_ONE;
        straps_raw.config_strap_zero    = CONFIG_STRAP_ZERO;
    end

    lcr_sync u_sync (
        .clk     (CLK),
        .arst_n  (ARST_N),
        .pin_in  (straps_raw),
        .pin_out (straps)
    );

    // ----------------------------------------------
    // address decode
    // ----------------------------------------------
    // only exact offsets hit; all else is unmapped
    always_comb begin
        hit_c = 1'b0;
        hit_d = 1'b0;
        if (ADDR == `LCR_OFS_LANE_C) begin
            hit_c = 1'b1;
        end else if (ADDR == `LCR_OFS_LANE_D) begin
            hit_d = 1'b1;
        end
    end

    // ----------------------------------------------
    // lane registers
    // ----------------------------------------------
    // lane c register
    lcr_lane u_lane_c (
        .clk            (CLK),
        .arst_n         (ARST_N),
        .wr_hit         (WR && hit_c),
        .wdata          (WDATA),
        .global_cfg     (GLOBAL_CFG),
        .loopback_all   (LOOPBACK_ALL),
        .power_down_all (POWER_DOWN_ALL),
        .straps         (straps),
        .ctrl_val       (c_val),
        .eff            (LANE_C_CTRL)
    );

    // lane d register
    lcr_lane u_lane_d (
        .clk            (CLK),
        .arst_n         (ARST_N),
        .wr_hit         (WR && hit_d),
        .wdata          (WDATA),
        .global_cfg     (GLOBAL_CFG),
        .loopback_all   (LOOPBACK_ALL),
        .power_down_all (POWER_DOWN_ALL),
        .straps         (straps),
        .ctrl_val       (d_val),
        .eff            (LANE_D_CTRL)
    );

    // ----------------------------------------------
    // read path
    // ----------------------------------------------
    // data stand only in the cycle after the strobe
    always_comb begin
        rdata_next = '0;
        if (RD && hit_c) begin
            rdata_next = c_val;
        end else if (RD && hit_d) begin
            rdata_next = d_val; // upper nibble is zero
        end
    end

    // ----------------------------------------------
    // multifunction pin
    // ----------------------------------------------
    // source chosen by merged select of lane d
    always_comb begin
        case (LANE_D_CTRL.mf_sel)
            `LCR_MF_IOSTD: mf_next = straps.io_std_hstl;
            `LCR_MF_COMMA: mf_next = LANE_D_COMMA_DETECTED;
            `LCR_MF_LOSS:  mf_next = LANE_D_SIGNAL_LOSS;
            default:       mf_next = LANE_D_PATTERN_TEST_PASS;
        endcase
    end

    // ----------------------------------------------
    // output registers
    // ----------------------------------------------
    // registers only
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_reg <= '0;
            mf_reg    <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            mf_reg    <= mf_next;
        end
    end

    assign RDATA                    = rdata_reg;
    assign LANE_D_MULTIFUNCTION_PIN = mf_reg;

    // ----------------------------------------------
    // assertions
    // ----------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    // a write to lane d with all straps low
    sequence s_wr_d_open;
        WR && hit_d && !straps.config_strap_one
        && !straps.config_strap_zero && !straps.pattern_test_strap;
    endsequence

    // a read of lane d
    sequence s_rd_d;
        RD && hit_d;
    endsequence

    // reserved nibble reads zero
    property p_resv_zero;
        s_rd_d |=> RDATA[15:12] == 4'h0;
    endproperty
    a_resv_zero: assert property (p_resv_zero)
        else $error("reserved bits read nonzero");

    // open write lands, then merged ctc follows
    property p_ctc_merge;
        s_wr_d_open ##1 !GLOBAL_CFG[11] |=>
            LANE_D_CTRL.ctc == $past(WDATA[11], 2);
    endproperty
    a_ctc_merge: assert property (p_ctc_merge)
        else $error("clock compensation merge wrong");

    // loss select drives pin from loss status
    property p_mf_loss;
        LANE_D_CTRL.mf_sel == 2'h2 |=> LANE_D_MULTIFUNCTION_PIN
            == $past(LANE_D_SIGNAL_LOSS);
    endproperty
    a_mf_loss: assert property (p_mf_loss)
        else $error("pin not showing signal loss");

    // pass select drives pin from pattern status
    property p_mf_pass;
        LANE_D_CTRL.mf_sel == 2'h3 |=> LANE_D_MULTIFUNCTION_PIN
            == $past(LANE_D_PATTERN_TEST_PASS);
    endproperty
    a_mf_pass: assert property (p_mf_pass)
        else $error("pin not showing pattern pass");

    // select is the OR of lane and global fields
    property p_mf_or;
        1 |=> LANE_D_CTRL.mf_sel == ($past(d_val[10:9]) | $past(GLOBAL_CFG[10:9]));
    endproperty
    a_mf_or: assert property (p_mf_or)
        else $error("pin select merge wrong");

    // loss detection needs both enables
    property p_los_and;
        1 |=> LANE_D_CTRL.los_en == ($past(d_val[8]) && $past(GLOBAL_CFG[8]));
    endproperty
    a_los_and: assert property (p_los_and)
        else $error("loss enable merge wrong");

    // bit 7 held while its strap is high
    property p_cfg1_lock;
        WR && hit_d && straps.config_strap_one |=> d_val[7] == $past(d_val[7]);
    endproperty
    a_cfg1_lock: assert property (p_cfg1_lock)
        else $error("bit 7 changed under strap");

    // bit 6 held while its strap is high
    property p_cfg0_lock;
        WR && hit_d && straps.config_strap_zero |=> d_val[6] == $past(d_val[6]);
    endproperty
    a_cfg0_lock: assert property (p_cfg0_lock)
        else $error("bit 6 changed under strap");

    // emphasis bits merged by OR
    property p_emph_or;
        1 |=> {LANE_D_CTRL.emph_high, LANE_D_CTRL.emph_low}
            == ($past(d_val[5:4]) | $past(GLOBAL_CFG[5:4]));
    endproperty
    a_emph_or: assert property (p_emph_or)
        else $error("emphasis merge wrong");

    // lane d loopback forced by loopback-all
    property p_d_loop;
        LOOPBACK_ALL |=> LANE_D_CTRL.loopback;
    endproperty
    a_d_loop: assert property (p_d_loop)
        else $error("lane d loopback not forced");

    // lane d pattern bit held under test strap
    property p_d_pat_lock;
        WR && hit_d && straps.pattern_test_strap |=> d_val[2] == $past(d_val[2]);
    endproperty
    a_d_pat_lock: assert property (p_d_pat_lock)
        else $error("lane d pattern bit changed under strap");

    // lane d alignment needs all three
    property p_d_align;
        1 |=> LANE_D_CTRL.align_en == ($past(d_val[1])
            && $past(straps.alignment_enable_pin) && $past(GLOBAL_CFG[1]));
    endproperty
    a_d_align: assert property (p_d_align)
        else $error("lane d alignment merge wrong");

    // lane d power down after open write of one
    property p_d_pdown;
        s_wr_d_open ##0 WDATA[0] |=> ##1 LANE_D_CTRL.power_down;
    endproperty
    a_d_pdown: assert property (p_d_pdown)
        else $error("lane d not powered down");

    // lane c loopback merge
    property p_c_loop;
        1 |=> LANE_C_CTRL.loopback == ($past(c_val[3]) || $past(LOOPBACK_ALL));
    endproperty
    a_c_loop: assert property (p_c_loop)
        else $error("lane c loopback merge wrong");

    // lane c pattern bit held under test strap
    property p_c_pat_lock;
        WR && hit_c && straps.pattern_test_strap |=> c_val[2] == $past(c_val[2]);
    endproperty
    a_c_pat_lock: assert property (p_c_pat_lock)
        else $error("lane c pattern bit changed under strap");

    // lane c alignment off when pin is low
    property p_c_align;
        !straps.alignment_enable_pin |=> !LANE_C_CTRL.align_en;
    endproperty
    a_c_align: assert property (p_c_align)
        else $error("lane c aligned without pin");

    // lane c power down forced by power-down-all
    property p_c_pdown;
        POWER_DOWN_ALL |=> LANE_C_CTRL.power_down;
    endproperty
    a_c_pdown: assert property (p_c_pdown)
        else $error("lane c power down not forced");

    // answer appears only after a read strobe
    property p_rd_only;
        !RD |=> RDATA == 16'h0000;
    endproperty
    a_rd_only: assert property (p_rd_only)
        else $error("read data outside answer cycle");
endmodule

// ### verification/lane_config_register_test.sv
// self-checking bench for the lane configuration register bank
`timescale 1ns/1ps
`include "lcr_defines.svh"
module lane_config_register_test
    import lcr_pkg::*;
;
// ----------------------------------------------
// stimulus and observed signals
// ----------------------------------------------
logic                   clk           = 1'b0;     // 100 MHz clock
logic                   arst_n        = 1'b0;     // async reset, low active
logic [`LCR_ADDR_W-1:0] addr          = 5'h00;    // register address
logic [`LCR_DATA_W-1:0] wdata         = 16'h0000; // write data
logic                   wr            = 1'b0;     // write strobe
logic                   rd            = 1'b0;     // read strobe
logic [`LCR_DATA_W-1:0] rdata;                    // read answer
logic [`LCR_DATA_W-1:0] global_cfg    = 16'h0102; // global config word
logic                   loopback_all  = 1'b0;     // global loopback
logic                   power_down_all = 1'b0;    // global power down
logic [2:0]             strap         = 3'h0;     // one, zero, pattern straps
logic                   align_pin     = 1'b1;     // alignment enable pin
logic [3:0]             src           = 4'h0;     // pass, loss, comma, io std
logic                   mf_pin;                   // multifunction pin
lcr_eff_t               c_ctrl;                   // lane c merged controls
lcr_eff_t               d_ctrl;                   // lane d merged controls
int                     error_cnt     = 0;        // mismatches seen
int                     n_compared    = 0;        // comparisons made

always #5 clk = ~clk;

lcr_top dut (
    .CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .GLOBAL_CFG(global_cfg), .LOOPBACK_ALL(loopback_all),
    .POWER_DOWN_ALL(power_down_all), .CONFIG_STRAP_ZERO(strap[1]),
    .CONFIG_STRAP_ONE(strap[0]), .PATTERN_TEST_STRAP(strap[2]),
    .ALIGNMENT_ENABLE_PIN(align_pin), .IO_STD_HSTL(src[0]),
    .LANE_D_COMMA_DETECTED(src[1]), .LANE_D_SIGNAL_LOSS(src[2]),
    .LANE_D_PATTERN_TEST_PASS(src[3]), .LANE_D_MULTIFUNCTION_PIN(mf_pin),
    .LANE_C_CTRL(c_ctrl), .LANE_D_CTRL(d_ctrl)
);
// ----------------------------------------------
// shared helpers
// ----------------------------------------------
// compare and count, report at once on a mismatch
task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want) begin
        error_cnt++;
        $display("BAD t=%0t seen %h expected %h", $time, seen, want);
    end
endtask
// verdict and end of run
task automatic final_report();
    if (error_cnt == 0 && n_compared > 0) begin
        $display("TEST PASSED");
    end else begin
        $display("TEST FAILED");
    end
    $finish;
endtask
// one-cycle write strobe
task automatic bus_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
endtask
// one-cycle read strobe, data taken in the following cycle only
task automatic bus_rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
endtask
// let n edges pass, then sample settled values
task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
endtask
// expected merged controls of one lane
function automatic lcr_eff_t exp_eff(input logic [15:0] r, input logic [15:0] g,
                                     input logic lb, input logic pd, input logic pin);
    lcr_eff_t e;
    e.ctc        = r[11] | g[11];
    e.mf_sel     = r[10:9] | g[10:9];
    e.los_en     = r[8] & g[8];
    e.cfg1       = r[7] | g[7];
    e.cfg0       = r[6] | g[6];
    e.emph_high  = r[5] | g[5];
    e.emph_low   = r[4] | g[4];
    e.loopback   = r[3] | lb;
    e.pattern_en = r[2] | g[2];
    e.align_en   = r[1] & pin & g[1];
    e.power_down = r[0] | pd;
    return e;
endfunction
// ----------------------------------------------
// scenarios
// ----------------------------------------------
// reset values read back and reach the merged outputs
task automatic t_reset();
    logic [15:0] v;
    bus_rd(`LCR_OFS_LANE_D, v);
    check(v, 16'h0102);
    bus_rd(`LCR_OFS_LANE_C, v);
    check(v, 16'h0102);
    check(16'(d_ctrl), 16'(exp_eff(16'h0102, global_cfg, 1'b0, 1'b0, 1'b1)));
    check(16'(c_ctrl), 16'(exp_eff(16'h0102, global_cfg, 1'b0, 1'b0, 1'b1)));
endtask
// reserved bits, unmapped place, read data lasting one cycle
task automatic t_reserved();
    logic [15:0] v;
    bus_wr(`LCR_OFS_LANE_D, 16'hffff);
    bus_wr(`LCR_OFS_LANE_C, 16'hffff);
    bus_wr(5'h15, 16'h0000);
    bus_rd(`LCR_OFS_LANE_D, v);
    check(v, 16'h0fff);
    settle(1);
    check(rdata, 16'h0000);
    bus_rd(`LCR_OFS_LANE_C, v);
    check(v, 16'h0fff);
    bus_rd(5'h15, v);
    check(v, 16'h0000);
endtask
// each strap alone holds only its own bit in both lanes
task automatic t_lock();
    logic [15:0] v;
    logic [15:0] mask [3] = '{16'h0080, 16'h0040, 16'h0004};
    for (int i = 0; i < 3; i++) begin
        bus_wr(`LCR_OFS_LANE_D, 16'h00c4);
        bus_wr(`LCR_OFS_LANE_C, 16'h00c4);
        strap <= 3'(1 << i);
        settle(8);
        bus_wr(`LCR_OFS_LANE_D, 16'h0000);
        bus_wr(`LCR_OFS_LANE_C, 16'h0000);
        bus_rd(`LCR_OFS_LANE_D, v);
        check(v, mask[i]);
        bus_rd(`LCR_OFS_LANE_C, v);
        check(v, mask[i]);
        @(posedge clk);
        strap <= 3'h0;
        settle(8);
    end
endtask
// merging with global word, loopback-all, power-down-all, alignment pin
task automatic t_merge();
    logic [15:0] rv [4] = '{16'h0000, 16'h0fff, 16'h0a5a, 16'h0102};
    logic [15:0] gv [4] = '{16'h0000, 16'hffff, 16'h0525, 16'h0102};
    for (int i = 0; i < 4; i++) begin
        bus_wr(`LCR_OFS_LANE_D, rv[i]);
        bus_wr(`LCR_OFS_LANE_C, rv[3-i]);
        global_cfg     <= gv[i];
        loopback_all   <= i[0];
        power_down_all <= i[1];
        align_pin      <= (i != 1);
        settle(8);
        check(16'(d_ctrl), 16'(exp_eff(rv[i], gv[i], i[0], i[1], i != 1)));
        check(16'(c_ctrl), 16'(exp_eff(rv[3-i], gv[i], i[0], i[1], i != 1)));
    end
endtask
// every pin source selected, each at both levels, then global select merge
task automatic t_pin();
    global_cfg <= 16'h0000;
    for (int s = 0; s < 4; s++) begin
        bus_wr(`LCR_OFS_LANE_D, 16'(s) << 9);
        for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            src <= v[0] ? 4'(1 << s) : ~4'(1 << s);
            settle(8);
            check(16'(mf_pin), 16'(v));
        end
    end
    bus_wr(`LCR_OFS_LANE_D, 16'h0200);
    global_cfg <= 16'h0400;
    src        <= 4'h8;
    settle(6);
    check(16'(mf_pin), 16'h0001);
endtask
// mid-run reset clears a written lane back to its defaults
task automatic t_rerst();
    logic [15:0] v;
    bus_wr(`LCR_OFS_LANE_D, 16'h0a5a);
    arst_n <= 1'b0;
    settle(2);
    check(rdata, 16'h0000);
    check(16'(d_ctrl), 16'h0000);
    @(posedge clk);
    arst_n <= 1'b1;
    settle(6);
    bus_rd(`LCR_OFS_LANE_D, v);
    check(v, 16'h0102);
    check(16'(d_ctrl),
          16'(exp_eff(16'h0102, global_cfg, loopback_all, power_down_all, align_pin)));
endtask
// ----------------------------------------------
// main sequence and watchdog
// ----------------------------------------------
initial begin
    repeat (5) @(posedge clk);
    #1;
    check(rdata, 16'h0000);
    check(16'(d_ctrl), 16'h0000);
    @(posedge clk);
    arst_n <= 1'b1;
    settle(6);
    t_reset();
    t_reserved();
    t_lock();
    t_merge();
    t_pin();
    t_rerst();
    final_report();
end

initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report();
end
endmodule
